/* shared/cmpc_defs.svh */
// register offsets, field positions and reset values of the comparator control block
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

// byte offsets on the register bus
`define CMPC_OFF_CTRL0     8'h00
`define CMPC_OFF_CTRL1     8'h04
`define CMPC_STRIDE        8'h08
`define CMPC_OFF_FLAGS     8'h18
`define CMPC_OFF_IRQEN     8'h1C
`define CMPC_OFF_MIRROR    8'h20
`define CMPC_OFF_ASEL      8'h24
`define CMPC_OFF_PINDIR    8'h28
`define CMPC_OFF_PORT      8'h2C

// comparator_control_zero fields
`define CMPC_B_ON          7
`define CMPC_B_RESULT      6
`define CMPC_B_PINOE       5
`define CMPC_B_INVERT      4
`define CMPC_B_SPEED       2
`define CMPC_B_HYST        1
`define CMPC_B_SYNC        0

// comparator_control_one fields
`define CMPC_B_RISE        7
`define CMPC_B_FALL        6
`define CMPC_B_POS_HI      5
`define CMPC_B_POS_LO      4
`define CMPC_B_NEG_HI      1
`define CMPC_B_NEG_LO      0

// reset values and bus codes
`define CMPC_SPEED_RST     1'b1
`define CMPC_ZERO_WORD     32'h0000_0000
`define CMPC_HTRANS_BIT    1

`endif

/* shared/cmpc_pkg.sv */
// shared types of the comparator control block
package cmpc_pkg;

	// register bus data phase: writes finish at once, reads take one wait state
	typedef enum logic {
		CMPC_BUS_IDLE,
		CMPC_BUS_READ
	} cmpc_bus_e;

endpackage

/* hw/cmpc_sync_latch.sv */
// latch of comparator results on the falling edge of the timer clock
`timescale 1ns/10ps
`default_nettype none

module cmpc_sync_latch
	import cmpc_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             timer_clk,
	input  wire logic [WIDTH-1:0] sample_in,
	output var  logic [WIDTH-1:0] latched
);

	logic clk_s1;
	logic clk_s2;
	logic clk_s3;
	logic timer_fall;

	// ****************************************
	// timer clock crossing
	// ****************************************

	// timer clock is foreign to hclk: two flops first, third for the edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
		end else begin
			clk_s1 <= timer_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
		end
	end

	assign timer_fall = clk_s3 & ~clk_s2; // one-cycle pulse on each falling edge of the synchronised timer clock

	// ****************************************
	// falling edge latch
	// ****************************************

	// timer counts on the rise, so sampling on the fall keeps the gate still
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latched <= '0;
		end else if (timer_fall) begin
			latched <= sample_in;
		end
	end

	property p_latch_on_fall;
		@(posedge hclk) disable iff (!hresetn)
		timer_fall |=> (latched == $past(sample_in));
	endproperty
	a_latch_on_fall: assert property (p_latch_on_fall)
		else $error("latch missed a timer falling edge");

	property p_latch_holds;
		@(posedge hclk) disable iff (!hresetn)
		!timer_fall |=> $stable(latched);
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("latch changed without a timer falling edge");

endmodule // cmpc_sync_latch

`default_nettype wire

/* hw/cmpc_top.sv */
// comparator digital control with register bus slave
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_defs.svh"

module cmpc_top
	import cmpc_pkg::*;
#(
	parameter int NUM_CMP = 3,
	parameter int PORT_W  = 8
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output var  logic                 hreadyout,
	output var  logic [31:0]          hrdata,
	output var  logic                 hresp,
	input  wire logic [NUM_CMP-1:0]   analog_compare,
	input  wire logic                 timer_clk,
	input  wire logic [PORT_W-1:0]    port_pins,
	output var  logic [NUM_CMP-1:0]   comparator_on,
	output var  logic [NUM_CMP-1:0]   input_connect,
	output var  logic [NUM_CMP-1:0]   speed_power_select,
	output var  logic [NUM_CMP-1:0]   hysteresis_enable,
	output var  logic [2*NUM_CMP-1:0] positive_input_select,
	output var  logic [2*NUM_CMP-1:0] negative_input_select,
	output var  logic [NUM_CMP-1:0]   timer_gate_source,
	output var  logic [NUM_CMP-1:0]   pwm_shutdown_source,
	output var  logic [NUM_CMP-1:0]   output_pin,
	output var  logic [NUM_CMP-1:0]   output_pin_oe,
	output var  logic [NUM_CMP-1:0]   comparator_irq_request
);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	cmpc_bus_e            bus_state;
	logic                 wr_pend;
	logic [7:0]           wr_addr;
	logic [7:0]           rd_addr;
	logic [31:0]          next_rdata;
	logic                 accept;
	logic [NUM_CMP-1:0]   pin_output_enable;
	logic [NUM_CMP-1:0]   output_invert;
	logic [NUM_CMP-1:0]   output_sync_enable;
	logic [NUM_CMP-1:0]   rising_edge_irq_enable;
	logic [NUM_CMP-1:0]   falling_edge_irq_enable;
	logic [NUM_CMP-1:0]   comparator_irq_flag;
	logic [NUM_CMP-1:0]   comparator_irq_enable;
	logic [PORT_W-1:0]    analog_select;
	logic [PORT_W-1:0]    pin_direction;
	logic [NUM_CMP-1:0]   raw_s1;
	logic [NUM_CMP-1:0]   raw_s2;
	logic [PORT_W-1:0]    port_s1;
	logic [PORT_W-1:0]    port_s2;
	logic [NUM_CMP-1:0]   comparator_result;
	logic [NUM_CMP-1:0]   result_prev;
	logic [NUM_CMP-1:0]   rise_pulse;
	logic [NUM_CMP-1:0]   fall_pulse;
	logic [NUM_CMP-1:0]   set_vec;
	logic [NUM_CMP-1:0]   latched;

	// bits of cur that are high where prev was low
	function automatic logic [NUM_CMP-1:0] edge_up(
		input logic [NUM_CMP-1:0] cur,
		input logic [NUM_CMP-1:0] prev
	);
		return cur & ~prev;
	endfunction

	// byte offset of a comparator control word
	function automatic logic [7:0] ctrl_off(input int idx, input logic second);
		logic [7:0] base;
		base = second ? `CMPC_OFF_CTRL1 : `CMPC_OFF_CTRL0;
		return 8'(base + 8'(idx) * `CMPC_STRIDE);
	endfunction

	// ****************************************
	// register bus slave
	// ****************************************

	assign accept = hsel & hready & htrans[`CMPC_HTRANS_BIT];

	// writes land in the data phase; reads add one wait so data is registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_state <= CMPC_BUS_IDLE;
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			rd_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= `CMPC_ZERO_WORD;
			hresp     <= 1'b0;
		end else begin
			wr_pend <= accept & hwrite;
			if (accept) begin
				wr_addr <= haddr[7:0];
				rd_addr <= haddr[7:0];
			end
			case (bus_state)
				CMPC_BUS_IDLE: begin
					if (accept && !hwrite) begin
						bus_state <= CMPC_BUS_READ;
						hreadyout <= 1'b0;
					end
				end
				CMPC_BUS_READ: begin
					hrdata    <= next_rdata;
					hreadyout <= 1'b1;
					bus_state <= CMPC_BUS_IDLE;
				end
				default: begin
					bus_state <= CMPC_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		next_rdata = `CMPC_ZERO_WORD;
		for (int i = 0; i < NUM_CMP; i++) begin
			if (rd_addr == ctrl_off(i, 1'b0)) begin
				next_rdata[`CMPC_B_ON]     = comparator_on[i];
				next_rdata[`CMPC_B_RESULT] = comparator_result[i];
				next_rdata[`CMPC_B_PINOE]  = pin_output_enable[i];
				next_rdata[`CMPC_B_INVERT] = output_invert[i];
				next_rdata[`CMPC_B_SPEED]  = speed_power_select[i];
				next_rdata[`CMPC_B_HYST]   = hysteresis_enable[i];
				next_rdata[`CMPC_B_SYNC]   = output_sync_enable[i];
			end
			if (rd_addr == ctrl_off(i, 1'b1)) begin
				next_rdata[`CMPC_B_RISE] = rising_edge_irq_enable[i];
				next_rdata[`CMPC_B_FALL] = falling_edge_irq_enable[i];
				next_rdata[`CMPC_B_POS_HI:`CMPC_B_POS_LO] = positive_input_select[2*i +: 2];
				next_rdata[`CMPC_B_NEG_HI:`CMPC_B_NEG_LO] = negative_input_select[2*i +: 2];
			end
		end
		case (rd_addr)
			`CMPC_OFF_FLAGS:  next_rdata[NUM_CMP-1:0] = comparator_irq_flag;
			`CMPC_OFF_IRQEN:  next_rdata[NUM_CMP-1:0] = comparator_irq_enable;
			`CMPC_OFF_MIRROR: next_rdata[NUM_CMP-1:0] = comparator_result;
			`CMPC_OFF_ASEL:   next_rdata[PORT_W-1:0]  = analog_select;
			`CMPC_OFF_PINDIR: next_rdata[PORT_W-1:0]  = pin_direction;
			`CMPC_OFF_PORT:   next_rdata[PORT_W-1:0]  = port_s2 & ~analog_select;
			default: ;
		endcase
	end

	property p_read_wait;
		accept && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read did not take exactly one wait state");

	sequence s_port_read;
		accept && !hwrite && (haddr[7:0] == `CMPC_OFF_PORT);
	endsequence
	property p_port_analog_zero;
		s_port_read ##2 hreadyout |-> ((hrdata[PORT_W-1:0] & $past(analog_select)) == '0);
	endproperty
	a_port_analog_zero: assert property (p_port_analog_zero)
		else $error("analog pin read back as one");

	// ****************************************
	// control registers
	// ****************************************

	// speed resets to normal mode; every other field resets clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comparator_on           <= '0;
			pin_output_enable       <= '0;
			output_invert           <= '0;
			speed_power_select      <= {NUM_CMP{`CMPC_SPEED_RST}};
			hysteresis_enable       <= '0;
			output_sync_enable      <= '0;
			rising_edge_irq_enable  <= '0;
			falling_edge_irq_enable <= '0;
			positive_input_select   <= '0;
			negative_input_select   <= '0;
		end else if (wr_pend) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (wr_addr == ctrl_off(i, 1'b0)) begin
					comparator_on[i]      <= hwdata[`CMPC_B_ON];
					pin_output_enable[i]  <= hwdata[`CMPC_B_PINOE];
					output_invert[i]      <= hwdata[`CMPC_B_INVERT];
					speed_power_select[i] <= hwdata[`CMPC_B_SPEED];
					hysteresis_enable[i]  <= hwdata[`CMPC_B_HYST];
					output_sync_enable[i] <= hwdata[`CMPC_B_SYNC];
				end
				if (wr_addr == ctrl_off(i, 1'b1)) begin
					rising_edge_irq_enable[i]  <= hwdata[`CMPC_B_RISE];
					falling_edge_irq_enable[i] <= hwdata[`CMPC_B_FALL];
					// codes pass straight to the analog mux
					positive_input_select[2*i +: 2] <=
						hwdata[`CMPC_B_POS_HI:`CMPC_B_POS_LO];
					negative_input_select[2*i +: 2] <=
						hwdata[`CMPC_B_NEG_HI:`CMPC_B_NEG_LO];
				end
			end
		end
	end

	// interrupt enables and pin configuration words
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comparator_irq_enable <= '0;
			analog_select         <= '0;
			pin_direction         <= '0;
		end else if (wr_pend) begin
			if (wr_addr == `CMPC_OFF_IRQEN)
				comparator_irq_enable <= hwdata[NUM_CMP-1:0];
			if (wr_addr == `CMPC_OFF_ASEL)
				analog_select <= hwdata[PORT_W-1:0];
			if (wr_addr == `CMPC_OFF_PINDIR)
				pin_direction <= hwdata[PORT_W-1:0];
		end
	end

	// analog side follows the on bit one cycle later; off cuts every input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			input_connect <= '0;
		else
			input_connect <= comparator_on;
	end

	property p_off_disconnects;
		!comparator_on[0] ##1 !comparator_on[0] |-> !input_connect[0];
	endproperty
	a_off_disconnects: assert property (p_off_disconnects)
		else $error("inputs connected while comparator off");

	// ****************************************
	// result path and edge detection
	// ****************************************

	// analog decision is asynchronous to hclk, so it crosses two flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_s1  <= '0;
			raw_s2  <= '0;
			port_s1 <= '0;
			port_s2 <= '0;
		end else begin
			raw_s1  <= analog_compare;
			raw_s2  <= raw_s1;
			port_s1 <= port_pins;
			port_s2 <= port_s1;
		end
	end

	// an off comparator gives a low decision before invert, so toggling invert still moves it; toggling on moves it only while the analog decision is high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comparator_result <= '0;
			result_prev       <= '0;
		end else begin
			comparator_result <= (comparator_on & raw_s2) ^ output_invert;
			result_prev       <= comparator_result;
		end
	end

	assign rise_pulse = edge_up(comparator_result, result_prev);
	assign fall_pulse = edge_up(result_prev, comparator_result);
	assign set_vec    = (rise_pulse & rising_edge_irq_enable)
	                  | (fall_pulse & falling_edge_irq_enable);

	// flag set beats a clearing write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			comparator_irq_flag <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (set_vec[i])
					comparator_irq_flag[i] <= 1'b1;
				else if (wr_pend && wr_addr == `CMPC_OFF_FLAGS)
					comparator_irq_flag[i] <= hwdata[i];
			end
		end
	end

	// request to the outer interrupt controller; its global gates are not here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			comparator_irq_request <= '0;
		else
			comparator_irq_request <= comparator_irq_flag & comparator_irq_enable;
	end

	property p_pulse_single;
		rise_pulse[0] |=> !rise_pulse[0];
	endproperty
	a_pulse_single: assert property (p_pulse_single)
		else $error("rising pulse longer than one cycle");

	property p_flag_set;
		set_vec != '0 |=> ((comparator_irq_flag & $past(set_vec)) == $past(set_vec));
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("enabled edge did not set flag");

	sequence s_clear_with_edge;
		wr_pend && (wr_addr == `CMPC_OFF_FLAGS) && !hwdata[0] && set_vec[0];
	endsequence
	property p_set_wins;
		s_clear_with_edge |=> comparator_irq_flag[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clearing write lost a concurrent edge");

	sequence s_invert_toggle_off;
		$changed(output_invert[0]) && !comparator_on[0] && $stable(comparator_on[0]);
	endsequence
	property p_toggle_edge;
		s_invert_toggle_off |-> ##1 (rise_pulse[0] || fall_pulse[0]);
	endproperty
	a_toggle_edge: assert property (p_toggle_edge)
		else $error("polarity toggle while off gave no edge");

	// ****************************************
	// timer gate, pin and shutdown outputs
	// ****************************************

	cmpc_sync_latch #(
		.WIDTH (NUM_CMP)
	) u_sync_latch (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.timer_clk (timer_clk),
		.sample_in (comparator_result),
		.latched   (latched)
	);

	// sync bit picks the timer latched copy for gate and pin, otherwise the live result; shutdown is always live
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_gate_source   <= '0;
			pwm_shutdown_source <= '0;
			output_pin          <= '0;
			output_pin_oe       <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				timer_gate_source[i] <= output_sync_enable[i] ?
					latched[i] : comparator_result[i];
				output_pin[i] <= output_sync_enable[i] ?
					latched[i] : comparator_result[i];
			end
			pwm_shutdown_source <= comparator_result;
			// pin drives only when enabled and its direction is output
			output_pin_oe <= pin_output_enable & ~pin_direction[NUM_CMP-1:0];
		end
	end

	property p_pin_matches_gate;
		output_pin == timer_gate_source;
	endproperty
	a_pin_matches_gate: assert property (p_pin_matches_gate)
		else $error("pin and timer gate disagree");

endmodule // cmpc_top

`default_nettype wire

/* dv/cmpc_timer_far.sv */
// far-side model: prescaled companion timer clock, gated timer count and pwm shutdown input
`timescale 1ns/10ps
`default_nettype none

module cmpc_timer_far (
	input  wire logic        run,
	input  wire logic        gate,
	input  wire logic        shut_src,
	output var  logic        timer_clk,
	output var  logic [15:0] count,
	output var  logic        shutdown
);
	// ************************************************************
	// prescaled timer clock and timer counter
	// ************************************************************
	// clock stands low between bursts so no stray falling edge reaches the latch;
	// count moves on rising edges only, the latch on falling ones, so no race
	initial begin
		timer_clk = 1'b0;
		count     = 16'h0000;
		forever begin
			wait (run === 1'b1);
			#170 timer_clk = 1'b1;
			if (gate === 1'b1) count = count + 16'h0001;
			#170 timer_clk = 1'b0;
		end
	end
	// auto-restart: shutdown follows the comparator in a closed loop
	assign shutdown = shut_src;
endmodule // cmpc_timer_far

`default_nettype wire

/* dv/comparator_output_control_tb.sv */
// self-checking testbench of the comparator control block
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_defs.svh"

module comparator_output_control_tb
	import cmpc_pkg::*;
;
	// ************************************************************
	// signals
	// ************************************************************
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic        timer_run, timer_clk, shutdown;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, analog_compare, comparator_on, input_connect, speed_power_select;
	logic [2:0]  hysteresis_enable, timer_gate_source, pwm_shutdown_source, output_pin;
	logic [2:0]  output_pin_oe, comparator_irq_request;
	logic [5:0]  positive_input_select, negative_input_select;
	logic [7:0]  port_pins;
	logic [15:0] tcount;
	logic [31:0] ctl_seq [3] = '{32'h0000_0094, 32'h0000_0014, 32'h0000_0004};
	int          miscompares = 0, checked = 0, cycles = 0;

	// one slave, so its ready is the bus ready
	assign hready = hreadyout;

	cmpc_top i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hrdata, .hresp, .analog_compare, .timer_clk, .port_pins,
		.comparator_on, .input_connect, .speed_power_select, .hysteresis_enable,
		.positive_input_select, .negative_input_select, .timer_gate_source,
		.pwm_shutdown_source, .output_pin, .output_pin_oe, .comparator_irq_request
	);

	cmpc_timer_far i_far (
		.run(timer_run), .gate(timer_gate_source[0]), .shut_src(pwm_shutdown_source[0]),
		.timer_clk(timer_clk), .count(tcount), .shutdown(shutdown)
	);

	// ************************************************************
	// clock, timeout and verdict
	// ************************************************************
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic print_verdict();
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// a hung handshake must still end in the verdict
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end

	// ************************************************************
	// bus and compare tasks
	// ************************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// address phase held until ready, then data phase held until ready again
	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr_en;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(name, rd, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, timer_run} = '0;
		hsize = 3'b010;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		analog_compare = 3'b000;
		port_pins = 8'ha5;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset state, then speed and hysteresis bits
		chk("speed", 32'(speed_power_select), 32'h0000_0007);
		for (int i = 0; i < 3; i++) rdc("ctrl0", 8'(8 * i), 32'h0000_0004);
		wr(`CMPC_OFF_CTRL0, 32'h0000_0002);
		wt(2);
		chk("speed", 32'(speed_power_select), 32'h0000_0006);
		chk("hyst", 32'(hysteresis_enable), 32'h0000_0001);
		wr(`CMPC_OFF_CTRL0, 32'h0000_0004);
		wt(2);
		chk("hyst", 32'(hysteresis_enable), 32'h0000_0000);
		// every input select code on comparator 1
		for (int c = 0; c < 4; c++) begin
			wr(`CMPC_OFF_CTRL1 + `CMPC_STRIDE, 32'(c * 17));
			wt(2);
			chk("pos_sel", 32'(positive_input_select[3:2]), 32'(c));
			chk("neg_sel", 32'(negative_input_select[3:2]), 32'(c));
		end
		chk("connect", 32'(input_connect), 32'h0000_0000);
		wr(`CMPC_OFF_CTRL0, 32'h0000_0084);
		wt(3);
		chk("on", 32'(comparator_on), 32'h0000_0001);
		chk("connect", 32'(input_connect), 32'h0000_0001);
		// rising edge with the rise and interrupt enables set raises the flag
		wr(`CMPC_OFF_CTRL1, 32'h0000_0080);
		wr(`CMPC_OFF_IRQEN, 32'h0000_0001);
		analog_compare <= 3'b001;
		wt(8);
		rdc("mirror", `CMPC_OFF_MIRROR, 32'h0000_0001);
		rdc("ctrl0", `CMPC_OFF_CTRL0, 32'h0000_00c4);
		chk("gate", 32'(timer_gate_source), 32'h0000_0001);
		chk("shutdown", 32'({shutdown, pwm_shutdown_source}), 32'h0000_0009);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0001);
		chk("irq", 32'(comparator_irq_request), 32'h0000_0001);
		wr(`CMPC_OFF_FLAGS, 32'h0000_0000);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0000);
		// falling enable only: fall sets, rise does not
		wr(`CMPC_OFF_CTRL1, 32'h0000_0040);
		analog_compare <= 3'b000;
		wt(8);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0001);
		wr(`CMPC_OFF_FLAGS, 32'h0000_0000);
		analog_compare <= 3'b001;
		wt(8);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0000);
		// rising enable only; the clearing write lands in the cycle of the rise pulse
		wr(`CMPC_OFF_CTRL1, 32'h0000_0080);
		analog_compare <= 3'b000;
		wt(8);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0000);
		analog_compare <= 3'b001;
		wt(2);
		wr(`CMPC_OFF_FLAGS, 32'h0000_0000);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0001);
		wr(`CMPC_OFF_FLAGS, 32'h0000_0000);
		// invert while on, switch off, invert while off: each flips the result
		wr(`CMPC_OFF_CTRL1, 32'h0000_00c0);
		for (int k = 0; k < 3; k++) begin
			wr(`CMPC_OFF_CTRL0, ctl_seq[k]);
			wt(8);
			rdc("mirror", `CMPC_OFF_MIRROR, 32'(k % 2));
			rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0001);
			wr(`CMPC_OFF_FLAGS, 32'h0000_0000);
		end
		chk("connect", 32'(input_connect), 32'h0000_0000);
		// synchronous output: gate moves only on a timer falling edge
		wr(`CMPC_OFF_CTRL0, 32'h0000_0085);
		timer_run <= 1'b1;
		wt(30);
		timer_run <= 1'b0;
		wt(20);
		chk("gate", 32'(timer_gate_source), 32'h0000_0001);
		chk("count", 32'(tcount != 16'h0000), 32'h0000_0001);
		analog_compare <= 3'b000;
		wt(10);
		rdc("mirror", `CMPC_OFF_MIRROR, 32'h0000_0000);
		chk("gate", 32'({output_pin[0], timer_gate_source[0]}), 32'h0000_0003);
		timer_run <= 1'b1;
		wt(30);
		timer_run <= 1'b0;
		wt(20);
		chk("gate", 32'({output_pin[0], timer_gate_source[0]}), 32'h0000_0000);
		// pin drive, analog pins read as zero, unmapped place
		wr(`CMPC_OFF_CTRL0, 32'h0000_00a4);
		wr(`CMPC_OFF_PINDIR, 32'h0000_00fe);
		wt(3);
		chk("pin_oe", 32'(output_pin_oe), 32'h0000_0001);
		wr(`CMPC_OFF_PINDIR, 32'h0000_00ff);
		wr(`CMPC_OFF_ASEL, 32'h0000_000f);
		wt(3);
		chk("pin_oe", 32'(output_pin_oe), 32'h0000_0000);
		rdc("port", `CMPC_OFF_PORT, 32'h0000_00a0);
		wr(8'h40, 32'hffff_ffff);
		rdc("unmapped", 8'h40, 32'h0000_0000);
		chk("hresp", 32'(hresp), 32'h0000_0000);
		// second reset in mid-run brings every field back to its reset value
		hresetn <= 1'b0;
		wt(2);
		hresetn <= 1'b1;
		wt(1);
		chk("speed", 32'(speed_power_select), 32'h0000_0007);
		chk("on", 32'(comparator_on), 32'h0000_0000);
		rdc("ctrl0", `CMPC_OFF_CTRL0, 32'h0000_0004);
		rdc("flag", `CMPC_OFF_FLAGS, 32'h0000_0000);
		print_verdict();
	end
endmodule // comparator_output_control_tb

`default_nettype wire
